// ### hw/hrb_pkg.sv
/*
 * Constants for the drive holding register bank: register addresses,
 * field widths, accepted ranges and values loaded at reset.
 * Assumes a word-addressed holding register space with 16-bit data.
 */
package hrb_pkg;
	// Widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int TIME_W = 19;
	localparam int FREQ_W = 9;
	// Third trip record, read only
	localparam logic [15:0] A_TRIP_CAUSE = 16'h0026;
	localparam logic [15:0] A_TRIP_FREQ = 16'h0028;
	localparam logic [15:0] A_TRIP_CURR = 16'h002A;
	localparam logic [15:0] A_TRIP_VOLT = 16'h002B;
	localparam logic [15:0] A_TRIP_RUN_HI = 16'h002C;
	localparam logic [15:0] A_TRIP_RUN_LO = 16'h002D;
	localparam logic [15:0] A_TRIP_ON_HI = 16'h002E;
	localparam logic [15:0] A_TRIP_ON_LO = 16'h002F;
	// Per motor set, index 0 first set, index 1 second set
	localparam logic [15:0] A_ACC_HI [2] = '{16'h1014, 16'h1501};
	localparam logic [15:0] A_ACC_LO [2] = '{16'h1015, 16'h1502};
	localparam logic [15:0] A_DEC_HI [2] = '{16'h1016, 16'h1503};
	localparam logic [15:0] A_DEC_LO [2] = '{16'h1017, 16'h1504};
	localparam logic [15:0] A_BASE [2] = '{16'h101B, 16'h150C};
	localparam logic [15:0] A_MAX [2] = '{16'h101C, 16'h150D};
	// Shared settings
	localparam logic [15:0] A_DIR = 16'h1018;
	localparam logic [15:0] A_FREQ_SRC = 16'h1019;
	localparam logic [15:0] A_RUN_SRC = 16'h101A;
	localparam logic [15:0] A_AIN_SEL = 16'h101D;
	localparam logic [15:0] A_AIN_START_F = 16'h1020;
	localparam logic [15:0] A_AIN_END_F = 16'h1022;
	localparam logic [15:0] A_AIN_LEVEL = 16'h1023;
	// Accepted ranges
	localparam logic [31:0] TIME_MIN = 32'h0000_0001;
	localparam logic [31:0] TIME_MAX = 32'h0004_93E0;
	localparam logic [18:0] TIME_COARSE = 19'h0_2710;
	localparam logic [18:0] TIME_STEP = 19'h0_000A;
	localparam logic [15:0] FREQ_LOW = 16'h001E;
	localparam logic [15:0] FREQ_HIGH = 16'h0190;
	localparam logic [15:0] DIR_MAX = 16'h0001;
	localparam logic [15:0] FSRC_MAX_LOW = 16'h0003;
	localparam logic [15:0] FSRC_CALC = 16'h000A;
	localparam logic [15:0] RSRC_MIN = 16'h0001;
	localparam logic [15:0] RSRC_MAX = 16'h0003;
	localparam logic [15:0] AIN_SEL_MAX = 16'h0003;
	localparam logic [15:0] AIN_FREQ_MAX = 16'h0FA0;
	localparam logic [15:0] AIN_LEVEL_MAX = 16'h0064;
	// Analog select codes
	localparam logic [1:0] AIN_TERM = 2'h0;
	localparam logic [1:0] AIN_SUM = 2'h1;
	localparam logic [1:0] AIN_VOLT_KNOB = 2'h2;
	localparam logic [1:0] AIN_CURR_KNOB = 2'h3;
	// Reset values
	localparam logic [18:0] RST_TIME = 19'h0_03E8;
	localparam logic [8:0] RST_FREQ = 9'h03C;
	localparam logic [3:0] RST_FREQ_SRC = 4'h0;
	localparam logic [1:0] RST_RUN_SRC = 2'h1;
endpackage

// ### hw/hrb_top.sv
/*
 * Holding register bank of a motor drive: third trip record (read only),
 * ramp times, base and maximum frequency for two motor sets, source
 * selectors and analog input range mapping, with decoded setting outputs.
 * Assumes the network front end runs on MCLK and issues one-cycle
 * read or write strobes; trip values come from drive logic on MCLK.
 */
`timescale 1ns/1ps
module hrb_top (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// Holding register access
	input wire logic [15:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic REG_ACK,
	output logic REG_ERR,
	// Third trip record from drive logic
	input wire logic [15:0] TRIP_CAUSE,
	input wire logic [15:0] TRIP_FREQ,
	input wire logic [15:0] TRIP_CURR,
	input wire logic [15:0] TRIP_VOLT,
	input wire logic [31:0] TRIP_RUN_HOURS,
	input wire logic [31:0] TRIP_ON_HOURS,
	// Pins
	input wire logic ANALOG_SELECT_TERMINAL,
	input wire logic MOTOR_SET2,
	// Active settings
	output logic DIR_REVERSE,
	output logic [3:0] FREQ_SOURCE,
	output logic [1:0] RUN_SOURCE,
	output logic [18:0] ACCEL_TIME,
	output logic [18:0] DECEL_TIME,
	output logic [8:0] BASE_FREQ,
	output logic [8:0] MAX_FREQ,
	output logic ANALOG_USE_VOLT,
	output logic ANALOG_USE_CURR,
	output logic ANALOG_USE_KNOB,
	output logic [11:0] ANALOG_START_FREQ,
	output logic [11:0] ANALOG_END_FREQ,
	output logic [6:0] ANALOG_START_LEVEL
);
	// Stored settings
	logic [18:0] acc_q [2];
	logic [18:0] dec_q [2];
	logic [15:0] acc_stg_q [2];
	logic [15:0] dec_stg_q [2];
	logic [8:0] base_q [2];
	logic [8:0] max_q [2];
	logic [1:0] set_ok;
	logic dir_q;
	logic [3:0] fsrc_q;
	logic [1:0] rsrc_q;
	logic [1:0] ain_sel_q;
	logic [11:0] ain_start_q;
	logic [11:0] ain_end_q;
	logic [6:0] ain_level_q;
	logic term_s1_q, term_s2_q, set_s1_q, set_s2_q;
	logic ro_hit, sh_hit, sh_ok, rd_hit;
	logic [15:0] rd_val;

	// Hundredths are dropped from 100.00 s upward
	function automatic logic [18:0] eff_time(input logic [18:0] v);
		logic [18:0] r;
		r = v;
		if (v >= hrb_pkg::TIME_COARSE) begin
			r = v - (v % hrb_pkg::TIME_STEP);
		end
		return r;
	endfunction

	// Pin synchronisers, the first stage feeds only the second
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			term_s1_q <= 1'b0;
			term_s2_q <= 1'b0;
			set_s1_q <= 1'b0;
			set_s2_q <= 1'b0;
		end else begin
			term_s1_q <= ANALOG_SELECT_TERMINAL;
			term_s2_q <= term_s1_q;
			set_s1_q <= MOTOR_SET2;
			set_s2_q <= set_s1_q;
		end
	end

	// Per motor set ramp times and frequency limits
	for (genvar g = 0; g < 2; g++) begin : g_set
		logic h_ah, h_al, h_dh, h_dl, h_b, h_m, ok_al, ok_dl, ok_b, ok_m;
		logic [31:0] acc_new, dec_new;
		assign h_ah = REG_ADDR == hrb_pkg::A_ACC_HI[g];
		assign h_al = REG_ADDR == hrb_pkg::A_ACC_LO[g];
		assign h_dh = REG_ADDR == hrb_pkg::A_DEC_HI[g];
		assign h_dl = REG_ADDR == hrb_pkg::A_DEC_LO[g];
		assign h_b = REG_ADDR == hrb_pkg::A_BASE[g];
		assign h_m = REG_ADDR == hrb_pkg::A_MAX[g];
		// High word is staged; the pair is checked and committed on the low word,
		// so a legal new value never has to pass through an illegal one
		assign acc_new = {acc_stg_q[g], REG_WDATA};
		assign dec_new = {dec_stg_q[g], REG_WDATA};
		assign ok_al = acc_new >= hrb_pkg::TIME_MIN && acc_new <= hrb_pkg::TIME_MAX;
		assign ok_dl = dec_new >= hrb_pkg::TIME_MIN && dec_new <= hrb_pkg::TIME_MAX;
		assign ok_b = REG_WDATA >= hrb_pkg::FREQ_LOW && REG_WDATA <= {7'h00, max_q[g]};
		assign ok_m = REG_WDATA <= hrb_pkg::FREQ_HIGH && REG_WDATA >= hrb_pkg::FREQ_LOW
			&& REG_WDATA >= {7'h00, base_q[g]};
		assign set_ok[g] = h_ah | h_dh | (h_al & ok_al) | (h_dl & ok_dl) | (h_b & ok_b)
			| (h_m & ok_m);

		// Stored values change only on an accepted write
		always_ff @(posedge MCLK or negedge RST_B) begin
			if (!RST_B) begin
				acc_q[g] <= hrb_pkg::RST_TIME;
				dec_q[g] <= hrb_pkg::RST_TIME;
				acc_stg_q[g] <= 16'h0000;
				dec_stg_q[g] <= 16'h0000;
				base_q[g] <= hrb_pkg::RST_FREQ;
				max_q[g] <= hrb_pkg::RST_FREQ;
			end else if (REG_WR) begin
				if (h_ah) begin
					acc_stg_q[g] <= REG_WDATA;
				end
				if (h_dh) begin
					dec_stg_q[g] <= REG_WDATA;
				end
				if (h_al && ok_al) begin
					acc_q[g] <= acc_new[18:0];
				end
				if (h_dl && ok_dl) begin
					dec_q[g] <= dec_new[18:0];
				end
				if (h_b && ok_b) begin
					base_q[g] <= REG_WDATA[8:0];
				end
				if (h_m && ok_m) begin
					max_q[g] <= REG_WDATA[8:0];
				end
			end
		end
	end

	// Shared setting decode and range checks
	always_comb begin
		ro_hit = REG_ADDR >= hrb_pkg::A_TRIP_CAUSE && REG_ADDR <= hrb_pkg::A_TRIP_ON_LO;
		sh_hit = 1'b1;
		sh_ok = 1'b0;
		unique case (REG_ADDR)
			hrb_pkg::A_DIR: sh_ok = REG_WDATA <= hrb_pkg::DIR_MAX;
			hrb_pkg::A_FREQ_SRC: sh_ok = REG_WDATA <= hrb_pkg::FSRC_MAX_LOW
				|| REG_WDATA == hrb_pkg::FSRC_CALC;
			hrb_pkg::A_RUN_SRC: sh_ok = REG_WDATA >= hrb_pkg::RSRC_MIN
				&& REG_WDATA <= hrb_pkg::RSRC_MAX;
			hrb_pkg::A_AIN_SEL: sh_ok = REG_WDATA <= hrb_pkg::AIN_SEL_MAX;
			hrb_pkg::A_AIN_START_F: sh_ok = REG_WDATA <= hrb_pkg::AIN_FREQ_MAX;
			hrb_pkg::A_AIN_END_F: sh_ok = REG_WDATA <= hrb_pkg::AIN_FREQ_MAX;
			hrb_pkg::A_AIN_LEVEL: sh_ok = REG_WDATA <= hrb_pkg::AIN_LEVEL_MAX;
			default: sh_hit = 1'b0;
		endcase
	end

	// Shared settings
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			dir_q <= 1'b0;
			fsrc_q <= hrb_pkg::RST_FREQ_SRC;
			rsrc_q <= hrb_pkg::RST_RUN_SRC;
			ain_sel_q <= hrb_pkg::AIN_TERM;
			ain_start_q <= 12'h000;
			ain_end_q <= 12'h000;
			ain_level_q <= 7'h00;
		end else if (REG_WR && sh_hit && sh_ok) begin
			unique case (REG_ADDR)
				hrb_pkg::A_DIR: dir_q <= REG_WDATA[0];
				hrb_pkg::A_FREQ_SRC: fsrc_q <= REG_WDATA[3:0];
				hrb_pkg::A_RUN_SRC: rsrc_q <= REG_WDATA[1:0];
				hrb_pkg::A_AIN_SEL: ain_sel_q <= REG_WDATA[1:0];
				hrb_pkg::A_AIN_START_F: ain_start_q <= REG_WDATA[11:0];
				hrb_pkg::A_AIN_END_F: ain_end_q <= REG_WDATA[11:0];
				hrb_pkg::A_AIN_LEVEL: ain_level_q <= REG_WDATA[6:0];
				default: ain_level_q <= ain_level_q;
			endcase
		end
	end

	// Read mux; high ramp words read back the stored value, not the stage
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 16'h0000;
		unique case (REG_ADDR)
			hrb_pkg::A_TRIP_CAUSE: rd_val = TRIP_CAUSE;
			hrb_pkg::A_TRIP_FREQ: rd_val = TRIP_FREQ;
			hrb_pkg::A_TRIP_CURR: rd_val = TRIP_CURR;
			hrb_pkg::A_TRIP_VOLT: rd_val = TRIP_VOLT;
			hrb_pkg::A_TRIP_RUN_HI: rd_val = TRIP_RUN_HOURS[31:16];
			hrb_pkg::A_TRIP_RUN_LO: rd_val = TRIP_RUN_HOURS[15:0];
			hrb_pkg::A_TRIP_ON_HI: rd_val = TRIP_ON_HOURS[31:16];
			hrb_pkg::A_TRIP_ON_LO: rd_val = TRIP_ON_HOURS[15:0];
			hrb_pkg::A_ACC_HI[0]: rd_val = {13'h0000, acc_q[0][18:16]};
			hrb_pkg::A_ACC_LO[0]: rd_val = acc_q[0][15:0];
			hrb_pkg::A_DEC_HI[0]: rd_val = {13'h0000, dec_q[0][18:16]};
			hrb_pkg::A_DEC_LO[0]: rd_val = dec_q[0][15:0];
			hrb_pkg::A_ACC_HI[1]: rd_val = {13'h0000, acc_q[1][18:16]};
			hrb_pkg::A_ACC_LO[1]: rd_val = acc_q[1][15:0];
			hrb_pkg::A_DEC_HI[1]: rd_val = {13'h0000, dec_q[1][18:16]};
			hrb_pkg::A_DEC_LO[1]: rd_val = dec_q[1][15:0];
			hrb_pkg::A_BASE[0]: rd_val = {7'h00, base_q[0]};
			hrb_pkg::A_MAX[0]: rd_val = {7'h00, max_q[0]};
			hrb_pkg::A_BASE[1]: rd_val = {7'h00, base_q[1]};
			hrb_pkg::A_MAX[1]: rd_val = {7'h00, max_q[1]};
			hrb_pkg::A_DIR: rd_val = {15'h0000, dir_q};
			hrb_pkg::A_FREQ_SRC: rd_val = {12'h000, fsrc_q};
			hrb_pkg::A_RUN_SRC: rd_val = {14'h0000, rsrc_q};
			hrb_pkg::A_AIN_SEL: rd_val = {14'h0000, ain_sel_q};
			hrb_pkg::A_AIN_START_F: rd_val = {4'h0, ain_start_q};
			hrb_pkg::A_AIN_END_F: rd_val = {4'h0, ain_end_q};
			hrb_pkg::A_AIN_LEVEL: rd_val = {9'h000, ain_level_q};
			default: rd_hit = 1'b0;
		endcase
	end

	// Answer one cycle after the strobe; a write takes precedence over a read
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_ACK <= 1'b0;
			REG_ERR <= 1'b0;
			REG_RDATA <= 16'h0000;
		end else begin
			REG_ACK <= REG_WR | REG_RD;
			if (REG_WR) begin
				// Read-only trip words and unmapped words refuse writes
				REG_ERR <= ro_hit | !((sh_hit & sh_ok) | (|set_ok));
				REG_RDATA <= 16'h0000;
			end else if (REG_RD) begin
				REG_ERR <= !rd_hit;
				REG_RDATA <= rd_val;
			end else begin
				REG_ERR <= 1'b0;
			end
		end
	end

	// Active-set outputs, selected by the motor set pin
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ACCEL_TIME <= hrb_pkg::RST_TIME;
			DECEL_TIME <= hrb_pkg::RST_TIME;
			BASE_FREQ <= hrb_pkg::RST_FREQ;
			MAX_FREQ <= hrb_pkg::RST_FREQ;
		end else begin
			ACCEL_TIME <= eff_time(acc_q[set_s2_q]);
			DECEL_TIME <= eff_time(dec_q[set_s2_q]);
			BASE_FREQ <= base_q[set_s2_q];
			MAX_FREQ <= max_q[set_s2_q];
		end
	end

	// Shared setting outputs and analog input routing
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			DIR_REVERSE <= 1'b0;
			FREQ_SOURCE <= hrb_pkg::RST_FREQ_SRC;
			RUN_SOURCE <= hrb_pkg::RST_RUN_SRC;
			ANALOG_USE_VOLT <= 1'b1;
			ANALOG_USE_CURR <= 1'b0;
			ANALOG_USE_KNOB <= 1'b0;
			ANALOG_START_FREQ <= 12'h000;
			ANALOG_END_FREQ <= 12'h000;
			ANALOG_START_LEVEL <= 7'h00;
		end else begin
			DIR_REVERSE <= dir_q;
			FREQ_SOURCE <= fsrc_q;
			RUN_SOURCE <= rsrc_q;
			ANALOG_START_FREQ <= ain_start_q;
			ANALOG_END_FREQ <= ain_end_q;
			ANALOG_START_LEVEL <= ain_level_q;
			unique case (ain_sel_q)
				hrb_pkg::AIN_TERM: begin
					ANALOG_USE_VOLT <= !term_s2_q;
					ANALOG_USE_CURR <= term_s2_q;
					ANALOG_USE_KNOB <= 1'b0;
				end
				hrb_pkg::AIN_SUM: begin
					ANALOG_USE_VOLT <= 1'b1;
					ANALOG_USE_CURR <= 1'b1;
					ANALOG_USE_KNOB <= 1'b0;
				end
				hrb_pkg::AIN_VOLT_KNOB: begin
					ANALOG_USE_VOLT <= !term_s2_q;
					ANALOG_USE_CURR <= 1'b0;
					ANALOG_USE_KNOB <= term_s2_q;
				end
				hrb_pkg::AIN_CURR_KNOB: begin
					ANALOG_USE_VOLT <= 1'b0;
					ANALOG_USE_CURR <= !term_s2_q;
					ANALOG_USE_KNOB <= term_s2_q;
				end
			endcase
		end
	end

	// Checks
	property p_trip_read;
		@(posedge MCLK) disable iff (!RST_B)
		REG_RD && !REG_WR && REG_ADDR == hrb_pkg::A_TRIP_CAUSE
			|=> REG_ACK && !REG_ERR && REG_RDATA == $past(TRIP_CAUSE);
	endproperty
	a_trip_read: assert property (p_trip_read) else $error("trip cause read wrong");

	property p_acc_range;
		@(posedge MCLK) disable iff (!RST_B)
		{13'h0000, acc_q[0]} >= hrb_pkg::TIME_MIN && {13'h0000, acc_q[0]} <= hrb_pkg::TIME_MAX;
	endproperty
	a_acc_range: assert property (p_acc_range) else $error("accel time out of range");

	property p_dec_range;
		@(posedge MCLK) disable iff (!RST_B)
		{13'h0000, dec_q[1]} >= hrb_pkg::TIME_MIN && {13'h0000, dec_q[1]} <= hrb_pkg::TIME_MAX;
	endproperty
	a_dec_range: assert property (p_dec_range) else $error("decel time out of range");

	property p_coarse;
		@(posedge MCLK) disable iff (!RST_B)
		ACCEL_TIME >= hrb_pkg::TIME_COARSE |-> ACCEL_TIME % hrb_pkg::TIME_STEP == 19'h0_0000;
	endproperty
	a_coarse: assert property (p_coarse) else $error("hundredths not dropped");

	property p_dir_reject;
		@(posedge MCLK) disable iff (!RST_B)
		REG_WR && REG_ADDR == hrb_pkg::A_DIR && REG_WDATA > hrb_pkg::DIR_MAX
			|=> REG_ERR && $stable(dir_q) ##1 DIR_REVERSE == $past(dir_q, 2);
	endproperty
	a_dir_reject: assert property (p_dir_reject) else $error("bad direction taken");

	property p_fsrc_legal;
		@(posedge MCLK) disable iff (!RST_B)
		{12'h000, fsrc_q} <= hrb_pkg::FSRC_MAX_LOW || {12'h000, fsrc_q} == hrb_pkg::FSRC_CALC;
	endproperty
	a_fsrc_legal: assert property (p_fsrc_legal) else $error("illegal frequency source");

	property p_rsrc_legal;
		@(posedge MCLK) disable iff (!RST_B)
		rsrc_q != 2'h0;
	endproperty
	a_rsrc_legal: assert property (p_rsrc_legal) else $error("illegal run source");

	property p_base_max;
		@(posedge MCLK) disable iff (!RST_B)
		base_q[0] <= max_q[0] && base_q[1] <= max_q[1]
			&& {7'h00, base_q[0]} >= hrb_pkg::FREQ_LOW;
	endproperty
	a_base_max: assert property (p_base_max) else $error("base above maximum");

	property p_max_range;
		@(posedge MCLK) disable iff (!RST_B)
		{7'h00, max_q[0]} <= hrb_pkg::FREQ_HIGH && {7'h00, max_q[1]} <= hrb_pkg::FREQ_HIGH;
	endproperty
	a_max_range: assert property (p_max_range) else $error("maximum above 400");

	property p_ain_sum;
		@(posedge MCLK) disable iff (!RST_B)
		(ain_sel_q == hrb_pkg::AIN_SUM) [*2] |-> ANALOG_USE_VOLT && ANALOG_USE_CURR
			&& !ANALOG_USE_KNOB;
	endproperty
	a_ain_sum: assert property (p_ain_sum) else $error("sum mode not routed");

	property p_ain_freq;
		@(posedge MCLK) disable iff (!RST_B)
		{4'h0, ain_start_q} <= hrb_pkg::AIN_FREQ_MAX && {4'h0, ain_end_q} <= hrb_pkg::AIN_FREQ_MAX;
	endproperty
	a_ain_freq: assert property (p_ain_freq) else $error("analog frequency out of range");

	property p_ain_level;
		@(posedge MCLK) disable iff (!RST_B)
		{9'h000, ain_level_q} <= hrb_pkg::AIN_LEVEL_MAX;
	endproperty
	a_ain_level: assert property (p_ain_level) else $error("analog level out of range");

	property p_ro_write;
		@(posedge MCLK) disable iff (!RST_B)
		REG_WR && REG_ADDR == hrb_pkg::A_TRIP_VOLT |=> REG_ACK && REG_ERR;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");
endmodule

// ### verification/drive_holding_register_bank_test.sv
/*
 * Self-checking bench for the holding register bank: trip record,
 * selectors, frequency limits, analog mapping and ramp time pairs.
 * Assumes hrb_top on a 40 MHz MCLK and the master model in hrb_master.
 */
`timescale 1ns/1ps
module drive_holding_register_bank_test;
	logic clk, rst_b, wr, rd, ack, err, term, set2, dir, uv, uc, uk;
	logic [15:0] addr, wdata, rdata, t_cause, t_freq, t_curr, t_volt, q;
	logic [31:0] t_run, t_on, v;
	logic [3:0] fsrc;
	logic [1:0] rsrc;
	logic [18:0] acc, dec;
	logic [8:0] base, maxf;
	logic [11:0] sf, ef;
	logic [6:0] lvl;
	logic e, g;
	int fails, checks, cyc;
	logic [15:0] sh [logic [15:0]];
	logic [31:0] ramp [4];
	logic [15:0] adr [11];
	logic [15:0] vals [17];
	logic [15:0] ta [8];
	logic [15:0] ev [8];

	hrb_top uut (.MCLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack), .REG_ERR(err),
		.TRIP_CAUSE(t_cause), .TRIP_FREQ(t_freq), .TRIP_CURR(t_curr), .TRIP_VOLT(t_volt),
		.TRIP_RUN_HOURS(t_run), .TRIP_ON_HOURS(t_on), .ANALOG_SELECT_TERMINAL(term),
		.MOTOR_SET2(set2), .DIR_REVERSE(dir), .FREQ_SOURCE(fsrc), .RUN_SOURCE(rsrc),
		.ACCEL_TIME(acc), .DECEL_TIME(dec), .BASE_FREQ(base), .MAX_FREQ(maxf),
		.ANALOG_USE_VOLT(uv), .ANALOG_USE_CURR(uc), .ANALOG_USE_KNOB(uk),
		.ANALOG_START_FREQ(sf), .ANALOG_END_FREQ(ef), .ANALOG_START_LEVEL(lvl));
	hrb_master master (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
		.rdata(rdata), .ack(ack), .err(err));

	// 25 ns clock
	always #12.5 clk = ~clk;

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Whether the bank should take a write, from the shadow of stored values
	function automatic logic ok_of(logic [15:0] a, logic [15:0] d);
		case (a)
			hrb_pkg::A_DIR: return d <= 16'h0001;
			hrb_pkg::A_FREQ_SRC: return d <= 16'h0003 || d == 16'h000A;
			hrb_pkg::A_RUN_SRC: return d >= 16'h0001 && d <= 16'h0003;
			hrb_pkg::A_AIN_SEL: return d <= 16'h0003;
			hrb_pkg::A_AIN_START_F, hrb_pkg::A_AIN_END_F: return d <= 16'h0FA0;
			hrb_pkg::A_AIN_LEVEL: return d <= 16'h0064;
			hrb_pkg::A_BASE[0]: return d >= 16'h001E && d <= sh[hrb_pkg::A_MAX[0]];
			hrb_pkg::A_BASE[1]: return d >= 16'h001E && d <= sh[hrb_pkg::A_MAX[1]];
			hrb_pkg::A_MAX[0]: return d <= 16'h0190 && d >= 16'h001E && d >= sh[hrb_pkg::A_BASE[0]];
			hrb_pkg::A_MAX[1]: return d <= 16'h0190 && d >= 16'h001E && d >= sh[hrb_pkg::A_BASE[1]];
			default: return 1'b0;
		endcase
	endfunction

	// Ramp time as used: hundredths dropped from 100.00 s upward
	function automatic logic [31:0] rt(logic [31:0] x);
		return (x >= 32'h0000_2710) ? x - (x % 32'h0000_000A) : x;
	endfunction

	// Analog input use as {volt, curr, knob}
	function automatic logic [2:0] ain(logic [1:0] s, logic t);
		case (s)
			2'h0: return t ? 3'h2 : 3'h4;
			2'h1: return 3'h6;
			2'h2: return t ? 3'h1 : 3'h4;
			default: return t ? 3'h1 : 3'h2;
		endcase
	endfunction

	// Settings outputs settle two cycles after the write strobe
	task automatic chk_out();
		repeat (2) @(negedge clk);
		check(32'(dir), 32'(sh[hrb_pkg::A_DIR][0]));
		check(32'(fsrc), 32'(sh[hrb_pkg::A_FREQ_SRC][3:0]));
		check(32'(rsrc), 32'(sh[hrb_pkg::A_RUN_SRC][1:0]));
		check(32'(base), 32'(sh[hrb_pkg::A_BASE[set2]][8:0]));
		check(32'(maxf), 32'(sh[hrb_pkg::A_MAX[set2]][8:0]));
		check(32'({uv, uc, uk}), 32'(ain(sh[hrb_pkg::A_AIN_SEL][1:0], term)));
		check(32'(sf), 32'(sh[hrb_pkg::A_AIN_START_F][11:0]));
		check(32'(ef), 32'(sh[hrb_pkg::A_AIN_END_F][11:0]));
		check(32'(lvl), 32'(sh[hrb_pkg::A_AIN_LEVEL][6:0]));
		check(32'(acc), rt(ramp[{set2, 1'b0}]));
		check(32'(dec), rt(ramp[{set2, 1'b1}]));
	endtask

	// Write, check acceptance, read back, then check the outputs
	task automatic wchk(input logic [15:0] a, input logic [15:0] d);
		logic ok;
		ok = ok_of(a, d);
		master.xfer(1'b1, a, d, q, e, g);
		check(32'({g, e}), 32'({1'b1, !ok}));
		if (ok) sh[a] = d;
		master.xfer(1'b0, a, 16'h0000, q, e, g);
		check(32'({g, e, q}), 32'({2'b10, sh[a]}));
		chk_out();
	endtask

	// Ramp pair: high word into the stage, low word commits when in range
	task automatic rwr(input logic [1:0] k, input logic [31:0] x);
		logic ok;
		logic [15:0] ah, al;
		ok = x >= 32'h0000_0001 && x <= 32'h0004_93E0;
		ah = k[0] ? hrb_pkg::A_DEC_HI[k[1]] : hrb_pkg::A_ACC_HI[k[1]];
		al = k[0] ? hrb_pkg::A_DEC_LO[k[1]] : hrb_pkg::A_ACC_LO[k[1]];
		master.xfer(1'b1, ah, x[31:16], q, e, g);
		check(32'({g, e}), 32'h2);
		master.xfer(1'b1, al, x[15:0], q, e, g);
		check(32'({g, e}), 32'({1'b1, !ok}));
		if (ok) ramp[k] = x;
		// Both words read back the stored pair, never a refused staged high word
		master.xfer(1'b0, ah, 16'h0000, q, e, g);
		check(32'({g, e, q}), 32'({2'b10, ramp[k][31:16]}));
		master.xfer(1'b0, al, 16'h0000, q, e, g);
		check(32'({g, e, q}), 32'({2'b10, ramp[k][15:0]}));
		chk_out();
	endtask

	initial begin
		void'($urandom(11924));
		clk = 1'b0;
		rst_b = 1'b0;
		term = 1'b0;
		set2 = 1'b0;
		{t_cause, t_freq, t_curr, t_volt} = {$urandom, $urandom};
		t_run = $urandom;
		t_on = $urandom;
		adr = '{hrb_pkg::A_DIR, hrb_pkg::A_FREQ_SRC, hrb_pkg::A_RUN_SRC, hrb_pkg::A_AIN_SEL,
			hrb_pkg::A_AIN_START_F, hrb_pkg::A_AIN_END_F, hrb_pkg::A_AIN_LEVEL,
			hrb_pkg::A_MAX[0], hrb_pkg::A_BASE[0], hrb_pkg::A_MAX[1], hrb_pkg::A_BASE[1]};
		vals = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h000A, 16'h000B,
			16'h001D, 16'h001E, 16'h003C, 16'h0064, 16'h0065, 16'h0190, 16'h0191,
			16'h0FA0, 16'h0FA1, 16'hFFFF};
		foreach (adr[i]) sh[adr[i]] = 16'h0000;
		sh[hrb_pkg::A_RUN_SRC] = 16'h0001;
		for (int s = 0; s < 2; s++) sh[hrb_pkg::A_MAX[s]] = 16'h003C;
		for (int s = 0; s < 2; s++) sh[hrb_pkg::A_BASE[s]] = 16'h003C;
		foreach (ramp[i]) ramp[i] = 32'h0000_03E8;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		chk_out();
		$display("test reset values done");
		// Trip record: every word readable, none writable, the 0x0027 hole unmapped
		ta = '{16'h0026, 16'h0028, 16'h002A, 16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h002F};
		ev = '{t_cause, t_freq, t_curr, t_volt, t_run[31:16], t_run[15:0], t_on[31:16], t_on[15:0]};
		foreach (ta[j]) begin
			master.xfer(1'b0, ta[j], 16'h0000, q, e, g);
			check(32'({g, e, q}), 32'({2'b10, ev[j]}));
			master.xfer(1'b1, ta[j], ~ev[j], q, e, g);
			check(32'({g, e}), 32'h3);
		end
		master.xfer(1'b0, 16'h0027, 16'h0000, q, e, g);
		check(32'({g, e, q}), 32'h3_0000);
		$display("test trip record done");
		// Every code and range edge on each setting, for both motor sets
		for (int s = 0; s < 2; s++) begin
			set2 = s[0];
			term = 1'($urandom);
			repeat (4) @(negedge clk);
			foreach (adr[i]) foreach (vals[j]) wchk(adr[i], vals[j]);
			repeat (20) wchk(adr[$urandom % 11], 16'($urandom % 512));
		end
		// Analog select under both terminal levels
		for (int c = 0; c < 4; c++) begin
			term = c[0];
			repeat (4) @(negedge clk);
			for (int k = 0; k < 4; k++) wchk(hrb_pkg::A_AIN_SEL, 16'(k));
		end
		$display("test settings done");
		// Ramp times: bounds, the 100 s edge and random values
		for (int s = 0; s < 2; s++) begin
			set2 = s[0];
			repeat (4) @(negedge clk);
			for (int k = 0; k < 2; k++) begin
				foreach (vals[j]) rwr({s[0], k[0]}, 32'(vals[j]));
				rwr({s[0], k[0]}, 32'h0004_93E0);
				rwr({s[0], k[0]}, 32'h0004_93E1);
				rwr({s[0], k[0]}, 32'h0000_270F);
				rwr({s[0], k[0]}, 32'h0000_2715);
				rwr({s[0], k[0]}, 32'h0001_0003);
				v = $urandom % 32'h0004_93E0 + 32'h1;
				rwr({s[0], k[0]}, v);
			end
		end
		$display("test ramp times done");
		final_report();
	end
endmodule

// ### verification/hrb_master.sv
/*
 * Network master model for the holding register bank: issues one-cycle
 * read or write strobes and collects the registered answer.
 * Assumes the bank answers exactly one MCLK cycle after the strobe edge.
 */
`timescale 1ns/1ps
module hrb_master (
	// Clock
	input wire logic clk,
	// Holding register access
	output logic [15:0] addr,
	output logic wr,
	output logic rd,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic ack,
	input wire logic err
);
	// Idle lines start from a known, quiet state
	initial begin
		addr = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 16'h0000;
	end

	// One transfer; a random idle cycle first so the bank sees slow and fast masters
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e, output logic got);
		repeat ($urandom_range(0, 1)) @(negedge clk);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(negedge clk);
		got = ack;
		q = rdata;
		e = err;
		wr = 1'b0;
		rd = 1'b0;
		// Released lines are scrambled so a stale value never passes
		addr = ~a;
		wdata = ~d;
	endtask
endmodule
